//--- hdl/refresh_generator.sv
// DRAM refresh generator with its control registers and power-save divider.
// Assumes a classic Wishbone master, single clock, synchronous reset.
//
// Notes on behaviour
// - Partition bits 15:9 form refresh A19-A13.
// - Reset clears the partition address field.
// - Partition low nine bits read zero, unwritable.
// - Nine address bits come from row counter.
// - Row counter is a maximal-length LFSR.
// - Prescaler holds nine-bit interval; upper reads zero.
// - Enable bit 15 arms refresh; reset clears.
// - Enable bits 14:9 read zero, ignore writes.
// - Enable low bits show live down counter.
// - Power-save enable plus three-bit divisor select.
// - Down counter decrements each output clock.
// - At one: request refresh, reload from prescaler.
// - Disable clears counter, keeps row counter.
// - Interrupt processing clears power-save enable.
`timescale 1ns/1ps
module refresh_generator
    import refresh_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Processor side
    input  wire logic        irq_taken,       // Pulse when an interrupt is processed
    // Bus interface unit side
    output logic             refresh_req,     // One-cycle refresh request
    output logic      [19:0] refresh_addr,    // Address for the refresh cycle
    output logic             output_clock_en  // Divided output clock enable
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [6:0]       part_q;      // partition_upper_address
    logic [6:0]       part_d;
    logic [CNT_W-1:0] presc_q;     // interval_count
    logic [CNT_W-1:0] presc_d;
    logic             ren_q;       // Refresh enable
    logic             ren_d;
    logic             pse_q;       // Power-save enable
    logic             pse_d;
    logic [DIV_W-1:0] dsel_q;      // divisor_select
    logic [DIV_W-1:0] dsel_d;

    // ------------------------------------------------------------
    // Refresh state
    // ------------------------------------------------------------
    logic [CNT_W-1:0] down_q;      // down_counter_value
    logic [CNT_W-1:0] down_d;
    logic [CNT_W-1:0] row_q;       // row_address_counter_bits
    logic [CNT_W-1:0] row_d;
    logic             req_q;
    logic             req_d;
    logic [19:0]      addr_q;
    logic [19:0]      addr_d;

    // ------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------
    logic [31:0]      rdat_q;
    logic [31:0]      rdat_d;
    logic             ack_q;
    logic             ack_d;
    logic             err_q;
    logic             err_d;

    // Internal strobes
    logic             req_new;     // New request accepted this cycle
    logic             wr_lo;       // Low byte lane of the selected half-word enabled
    logic             wr_hi;       // High byte lane of the selected half-word enabled
    logic             mapped;      // Address hits a register
    logic             tick;        // Output clock enable
    logic             tick_q;      // Registered copy for the output port
    logic [15:0]      wdat;        // Half-word selected by the address

    // ------------------------------------------------------------
    // Power-save divider
    // ------------------------------------------------------------
    clock_divider u_div (
        .ref_clk (ref_clk),
        .rst     (rst),
        .div_en  (pse_q),
        .div_sel (dsel_q),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Registers are 16 bits at half-word offsets; byte 2 selects the upper lanes.
    // Ack is given one cycle after the request and dropped the next, so a held
    // request is not taken again in the ack cycle.
    always_comb begin
        req_new = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
        mapped  = (wb_adr_i == OFS_PARTITION) || (wb_adr_i == OFS_PRESCALER) ||
                  (wb_adr_i == OFS_ENABLE)    || (wb_adr_i == OFS_POWER);
        if (wb_adr_i[1]) begin
            wdat  = wb_dat_i[31:16];
            wr_lo = wb_sel_i[2];
            wr_hi = wb_sel_i[3];
        end else begin
            wdat  = wb_dat_i[15:0];
            wr_lo = wb_sel_i[0];
            wr_hi = wb_sel_i[1];
        end
    end

    // ------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------
    always_comb begin
        part_d = part_q;
        presc_d = presc_q;
        ren_d = ren_q;
        pse_d = pse_q;
        dsel_d = dsel_q;
        if (req_new && wb_we_i) begin
            case (wb_adr_i)
                OFS_PARTITION: begin
                    // Bits 8:0 have no storage and ignore writes
                    if (wr_hi) part_d[6:0] = wdat[15:9];
                end
                OFS_PRESCALER: begin
                    if (wr_lo) presc_d[7:0] = wdat[7:0];
                    if (wr_hi) presc_d[8]   = wdat[8];
                end
                OFS_ENABLE: begin
                    // Only the enable bit is writable; count and 14:9 ignore writes
                    if (wr_hi) ren_d = wdat[EN_BIT];
                end
                OFS_POWER: begin
                    if (wr_hi) pse_d  = wdat[EN_BIT];
                    if (wr_lo) dsel_d = wdat[DIV_W-1:0];
                end
                default: begin
                    ren_d = ren_q;
                end
            endcase
        end
        // Interrupt processing wins over a same-cycle software set
        if (irq_taken) begin
            pse_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Refresh counter next values
    // ------------------------------------------------------------
    // Loading on enable uses the value being written, so a single bus
    // write both arms and primes the counter.
    always_comb begin
        down_d = down_q;
        row_d  = row_q;
        req_d  = 1'b0;
        addr_d = addr_q;
        if (!ren_d) begin
            down_d = '0;
        end else if (!ren_q) begin
            down_d = presc_d;
        end else if (tick) begin
            if (down_q == 9'h001) begin
                down_d = presc_q;
                req_d  = 1'b1;
                // Address uses the current row, then the LFSR steps
                addr_d = {part_q, ADDR_GAP, row_q, ADDR_LSB};
                row_d  = {row_q[CNT_W-2:0], ^(row_q & LFSR_TAPS)};
            end else begin
                down_d = down_q - 9'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus answer next values
    // ------------------------------------------------------------
    always_comb begin
        ack_d  = req_new && mapped;
        err_d  = req_new && !mapped;
        rdat_d = rdat_q;
        if (req_new) begin
            case (wb_adr_i)
                OFS_PARTITION: rdat_d = {16'h0000, part_q, 9'h000};
                OFS_PRESCALER: rdat_d = {16'h0000, 7'h00, presc_q};
                OFS_ENABLE:    rdat_d = {16'h0000, ren_q, 6'h00, down_q};
                OFS_POWER:     rdat_d = {16'h0000, pse_q, 12'h000, dsel_q};
                default:       rdat_d = 32'h0000_0000;
            endcase
            // Half-word registers at odd half addresses ride the upper lanes
            if (wb_adr_i[1]) begin
                rdat_d = {rdat_d[15:0], 16'h0000};
            end
        end
    end

    // ------------------------------------------------------------
    // Register stage
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            part_q  <= PART_RST;
            presc_q <= PRESC_RST;
            ren_q   <= 1'b0;
            pse_q   <= 1'b0;
            dsel_q  <= DIV_RST;
            down_q  <= '0;
            row_q   <= ROW_RST;
            req_q   <= 1'b0;
            addr_q  <= 20'h00000;
            rdat_q  <= 32'h0000_0000;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            tick_q  <= 1'b0;
        end else begin
            part_q  <= part_d;
            presc_q <= presc_d;
            ren_q   <= ren_d;
            pse_q   <= pse_d;
            dsel_q  <= dsel_d;
            down_q  <= down_d;
            row_q   <= row_d;
            req_q   <= req_d;
            addr_q  <= addr_d;
            rdat_q  <= rdat_d;
            ack_q   <= ack_d;
            err_q   <= err_d;
            tick_q  <= tick;
        end
    end

    // Outputs straight from flip-flops
    assign wb_dat_o        = rdat_q;
    assign wb_ack_o        = ack_q;
    assign wb_err_o        = err_q;
    assign refresh_req     = req_q;
    assign refresh_addr    = addr_q;
    assign output_clock_en = tick_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_addr_upper : assert property (@(posedge ref_clk) disable iff (rst)
        refresh_req |-> refresh_addr[19:13] == $past(part_q))
        else $error("refresh upper address not from partition");

    a_addr_fixed : assert property (@(posedge ref_clk) disable iff (rst)
        refresh_req |-> refresh_addr[12:10] == 3'h0 && refresh_addr[0])
        else $error("refresh fixed address bits wrong");

    a_row_source : assert property (@(posedge ref_clk) disable iff (rst)
        refresh_req |-> refresh_addr[9:1] == $past(row_q))
        else $error("row bits not from row counter");

    a_row_nonzero : assert property (@(posedge ref_clk) disable iff (rst)
        row_q != 9'h000)
        else $error("row counter locked at zero");

    a_reload_req : assert property (@(posedge ref_clk) disable iff (rst)
        (ren_q && ren_d && tick && down_q == 9'h001)
            |=> refresh_req && down_q == $past(presc_q))
        else $error("no request or reload at count one");

    a_decrement : assert property (@(posedge ref_clk) disable iff (rst)
        (ren_q && ren_d && tick && down_q > 9'h001)
            |=> down_q == $past(down_q) - 9'h001)
        else $error("counter did not decrement");

    a_disable_clr : assert property (@(posedge ref_clk) disable iff (rst)
        !ren_q |-> (down_q == 9'h000 && !refresh_req) ##1 row_q == $past(row_q))
        else $error("disabled counter not cleared");

    a_load_enable : assert property (@(posedge ref_clk) disable iff (rst)
        (!ren_q && ren_d) |=> down_q == $past(presc_d))
        else $error("counter not primed on enable");

    // Checked without disable so the reset branch itself is covered
    a_reset_clear : assert property (@(posedge ref_clk)
        rst |=> part_q == PART_RST && !ren_q && !pse_q)
        else $error("registers not cleared by reset");

    a_irq_exit : assert property (@(posedge ref_clk) disable iff (rst)
        irq_taken |=> !pse_q)
        else $error("power-save survived interrupt");

    a_hold_slow : assert property (@(posedge ref_clk) disable iff (rst)
        (ren_q && ren_d && !tick && $past(ren_q)) |=> $stable(down_q))
        else $error("counter moved without output clock");

    a_ack_pulse : assert property (@(posedge ref_clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule : refresh_generator

//--- hdl/refresh_pkg.sv
// Constants for the refresh generator and power-save clock divider.
// Assumes a single 125 MHz clock and a classic Wishbone register bus.
package refresh_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PARTITION = 8'he0;   // refresh_partition
    localparam logic [7:0] OFS_PRESCALER = 8'he2;   // refresh_interval_prescaler
    localparam logic [7:0] OFS_ENABLE    = 8'he4;   // refresh_enable_and_count
    localparam logic [7:0] OFS_POWER     = 8'hf0;   // power_save_control

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PART_LSB   = 9;    // partition_upper_address at 15:9
    localparam int EN_BIT     = 15;   // enable bits in enable and power regs
    localparam int CNT_W      = 9;    // interval_count, down counter, row counter
    localparam int DIV_W      = 3;    // divisor_select width

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [6:0] PART_RST  = 7'h00;
    localparam logic [8:0] PRESC_RST = 9'h000;
    localparam logic [8:0] ROW_RST   = 9'h001;   // Any nonzero LFSR seed
    localparam logic [2:0] DIV_RST   = 3'h0;

    // ------------------------------------------------------------
    // Refresh address fixed bits and LFSR taps
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_GAP   = 3'h0;    // A12..A10
    localparam logic       ADDR_LSB   = 1'b1;    // A0
    localparam logic [8:0] LFSR_TAPS  = 9'h110;  // x^9 + x^5 + 1, maximal length
    localparam logic [7:0] DIV_MAX    = 8'hff;   // Largest divide-by minus one

endpackage : refresh_pkg

//--- hdl/clock_divider.sv
// Power-save clock divider producing a one-cycle output clock enable.
// Assumes synchronous active-high reset; codes map to /1,/4,/8 .. /256.
`timescale 1ns/1ps
module clock_divider
    import refresh_pkg::*;
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Control
    input  wire logic             div_en,       // Power-save active
    input  wire logic [DIV_W-1:0] div_sel,      // divisor_select
    // Output
    output logic                  tick          // One pulse per output clock
);

    // ------------------------------------------------------------
    // Divider state
    // ------------------------------------------------------------
    logic [7:0] cnt_q;      // Cycles elapsed within a divided period
    logic [7:0] cnt_d;
    logic       tick_q;     // Registered enable pulse
    logic       tick_d;
    logic [7:0] last;       // Terminal count for the selected factor

    // Terminal count: code 0 is /1, code n is /2^(n+1)
    always_comb begin
        if (div_sel == DIV_RST) begin
            last = 8'h00;
        end else begin
            last = 8'((9'h002 << div_sel) - 9'h001);
        end
    end

    // Next count and pulse; undivided when power-save is off
    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!div_en || cnt_q >= last) begin
            cnt_d  = 8'h00;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    // Register stage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

    // With power-save on and code 7 selected, a pulse is never followed by another in the next cycle
    a_div_spacing : assert property (@(posedge ref_clk) disable iff (rst)
        (div_en && div_sel == 3'h7 && $stable(div_en) && tick_q)
            |=> !tick_q [*1])
        else $error("divided tick arrived too early");

endmodule : clock_divider

//--- verif/biu_model.sv
// Behavioural bus interface unit that executes refresh cycles on request.
// Assumes refresh_req is a one-cycle pulse and refresh_addr is valid with it.
`timescale 1ns/1ps
module biu_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Refresh request from the generator
    input  wire logic        refresh_req,
    input  wire logic [19:0] refresh_addr
);
    // ------------------------------------------------------------
    // Request log
    // ------------------------------------------------------------
    int          req_count;  // Requests taken since reset
    int          gap;        // Cycles between the last two requests
    int          since;      // Cycles since the last request
    logic [19:0] last_addr;  // Address of the last refresh cycle

    // Takes every request at once; the generator never waits on us
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_count <= 0;
            gap       <= 0;
            since     <= 0;
            last_addr <= 20'h00000;
        end else begin
            since <= since + 1;
            if (refresh_req === 1'b1) begin
                req_count <= req_count + 1;
                gap       <= since + 1;
                since     <= 0;
                last_addr <= refresh_addr;
            end
        end
    end
endmodule : biu_model

//--- verif/tb_top.sv
// Self-checking bench for the refresh generator and its registers.
// Assumes a classic Wishbone slave answering within a few cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top
    import refresh_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        cyc     = 1'b0;   // Wishbone cycle and strobe
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [3:0]  sel     = 4'h0;
    logic [31:0] dat     = 32'h0;
    logic        irq     = 1'b0;   // Interrupt processed pulse
    logic [31:0] dat_o;
    logic        ack;
    logic        err;
    logic        req;
    logic [19:0] addr;
    logic        clk_en;
    int          mismatches = 0;
    int          checks     = 0;
    logic [8:0]  seq [511];        // Row sequence over one period
    int          base0;            // Request index of seq[0]

    always #4 ref_clk = ~ref_clk;

    refresh_generator uut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .irq_taken(irq), .refresh_req(req),
        .refresh_addr(addr), .output_clock_en(clk_en));
    biu_model u_biu (.ref_clk(ref_clk), .rst(rst), .refresh_req(req), .refresh_addr(addr));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // A wait that ran out counts as a mismatch and ends the run
    task timed_out(input string nm);
        mismatches++;
        $display("mismatch %s expected 1 seen 0", nm);
        tally_and_finish();
    endtask : timed_out

    // One classic cycle; request held until ack or err is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= a[1] ? 4'hc : 4'h3;
        dat <= {d, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        if (ack !== 1'b1 && err !== 1'b1) timed_out("wb_ack");
        q = a[1] ? dat_o[31:16] : dat_o[15:0];
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic        e;
        bus(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        logic e;
        bus(1'b0, a, 16'h0000, q, e);
    endtask : rd

    task automatic wait_req(output logic [19:0] a);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (req !== 1'b1 && n < 2000);
        if (req !== 1'b1) timed_out("refresh_req");
        a = addr;
    endtask : wait_req

    // Cycles between the second and third output clock pulses
    task automatic tick_gap(output int g);
        int n;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (clk_en !== 1'b1 && n < 600);
            if (clk_en !== 1'b1) timed_out("output_clock_en");
            g = n;
        end
    endtask : tick_gap

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [15:0] q;
        logic        e;
        rd(OFS_PARTITION, q); `CHK("partition", 16'h0000, q)
        rd(OFS_ENABLE, q); `CHK("enable", 16'h0000, q)
        rd(OFS_POWER, q); `CHK("power", 16'h0000, q)
        bus(1'b1, 8'he8, 16'hffff, q, e); `CHK("unmapped err", 1'b1, e)
    endtask : t_reset

    // Reserved and read-only bits read zero whatever is written
    task automatic t_fields;
        logic [15:0] q;
        wr(OFS_PARTITION, 16'hffff);
        rd(OFS_PARTITION, q); `CHK("partition", 16'hfe00, q)
        wr(OFS_PRESCALER, 16'hffff);
        rd(OFS_PRESCALER, q); `CHK("prescaler", 16'h01ff, q)
        wr(OFS_ENABLE, 16'h7e00);
        rd(OFS_ENABLE, q); `CHK("enable", 16'h0000, q)
        wr(OFS_PARTITION, 16'ha400);
    endtask : t_fields

    // Requests back to back: address layout, period, disable and resume
    task automatic t_rows;
        logic [19:0]  a;
        logic [511:0] seen;
        logic [15:0]  q;
        int           n;
        seen = '0;
        wr(OFS_PRESCALER, 16'h0001);
        wr(OFS_ENABLE, 16'h8000);
        for (int i = 0; i < 512; i++) begin
            wait_req(a);
            if (i == 0) begin
                base0 = u_biu.req_count;
                `CHK("addr upper", 7'h52, a[19:13])
                `CHK("addr gap", 3'h0, a[12:10])
                `CHK("addr lsb", 1'b1, a[0])
            end
            if (i < 511) begin
                `CHK("row repeat", 1'b0, seen[a[9:1]])
                seen[a[9:1]] = 1'b1;
                seq[i]       = a[9:1];
            end else begin
                `CHK("row period", seq[0], a[9:1])
            end
        end
        wr(OFS_ENABLE, 16'h0000);
        rd(OFS_ENABLE, q); `CHK("count off", 16'h0000, q)
        n = u_biu.req_count;
        repeat (30) @(posedge ref_clk);
        `CHK("no request", n, u_biu.req_count)
        wr(OFS_PRESCALER, 16'h0003);
        wr(OFS_ENABLE, 16'h8000);
        wait_req(a);
        n = u_biu.req_count - base0;
        `CHK("row kept", seq[n % 511], a[9:1])
        wait_req(a);
        @(posedge ref_clk);
        `CHK("interval", 3, u_biu.gap)
    endtask : t_rows

    // Down counter visible and moving; writes to it are ignored
    task automatic t_live;
        logic [15:0] q;
        logic [15:0] r;
        wr(OFS_PRESCALER, 16'h0064);
        wr(OFS_ENABLE, 16'h81ff);
        rd(OFS_ENABLE, q);
        rd(OFS_ENABLE, r);
        `CHK("enable bit", 1'b1, q[15])
        `CHK("enable rsvd", 6'h00, q[14:9])
        `CHK("count range", 1'b1, q[8:0] <= 9'h064 && q[8:0] != 9'h000)
        `CHK("count moves", 1'b1, r[8:0] != q[8:0])
    endtask : t_live

    // Every divisor code, slowed refresh, then interrupt exit
    task automatic t_power;
        int          g;
        int          f [8] = '{1, 4, 8, 16, 32, 64, 128, 256};
        logic [15:0] q;
        logic [19:0] a;
        for (int c = 0; c < 8; c++) begin
            wr(OFS_POWER, 16'h8000 | 16'(c));
            rd(OFS_POWER, q); `CHK("power", 16'h8000 | 16'(c), q)
            tick_gap(g); `CHK("divide", f[c], g)
        end
        wr(OFS_POWER, 16'h8001);
        wr(OFS_PRESCALER, 16'h0002);
        wr(OFS_ENABLE, 16'h8000);
        wait_req(a);
        wait_req(a);
        @(posedge ref_clk);
        `CHK("slow interval", 8, u_biu.gap)
        irq <= 1'b1;
        @(posedge ref_clk);
        irq <= 1'b0;
        rd(OFS_POWER, q); `CHK("power exit", 16'h0001, q)
        tick_gap(g); `CHK("full speed", 1, g)
    endtask : t_power

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_fields();
        t_rows();
        t_live();
        t_power();
        tally_and_finish();
    end
endmodule : tb_top
